// [hdl/sppi_pkg.sv]
// Purpose: Shared constants for the strobed parallel I/O port.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package sppi_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] SPPI_OFF_DATA_A  = 8'h00;
  localparam logic [7:0] SPPI_OFF_DATA_B  = 8'h04;
  localparam logic [7:0] SPPI_OFF_DATA_C  = 8'h08;
  localparam logic [7:0] SPPI_OFF_CTRL    = 8'h0C;
  localparam logic [7:0] SPPI_OFF_STATUS  = 8'h10;
  localparam logic [7:0] SPPI_OFF_FIFO    = 8'h14;
  // ****************************************************************
  // Control word fields
  // ****************************************************************
  localparam int SPPI_CTL_DIR_A  = 0;
  localparam int SPPI_CTL_DIR_B  = 1;
  localparam int SPPI_CTL_DIR_CL = 2;
  localparam int SPPI_CTL_DIR_CH = 3;
  localparam int SPPI_CTL_MODE_A = 4;
  localparam int SPPI_CTL_MODE_B = 6;
  localparam int SPPI_CTL_IEN_A  = 7;
  localparam int SPPI_CTL_IEN_B  = 8;
  localparam int SPPI_CTL_W      = 9;
  localparam logic [8:0] SPPI_CTL_RESET = 9'h00F;
  // ****************************************************************
  // Modes and misc
  // ****************************************************************
  localparam logic [1:0] SPPI_MODE_SIMPLE  = 2'h0;
  localparam logic [1:0] SPPI_MODE_STROBED = 2'h1;
  localparam logic [1:0] SPPI_MODE_BIDIR   = 2'h2;
  localparam logic [1:0] SPPI_RESP_OKAY    = 2'h0;
  localparam logic [1:0] SPPI_RESP_SLVERR  = 2'h2;
  localparam int         SPPI_FIFO_DEPTH   = 8;
  // ****************************************************************
  // Third port handshake pin positions and status fields
  // ****************************************************************
  localparam int SPPI_PC_SRQ_B     = 0;
  localparam int SPPI_PC_FULL_B    = 1;
  localparam int SPPI_PC_HSK_B     = 2;
  localparam int SPPI_PC_SRQ_A     = 3;
  localparam int SPPI_PC_STROBE_A  = 4;
  localparam int SPPI_PC_INFULL_A  = 5;
  localparam int SPPI_PC_ACK_A     = 6;
  localparam int SPPI_PC_OUTFULL_A = 7;
  localparam int SPPI_STAT_LEVEL   = 8;
endpackage

// [hdl/sppi_fifo.sv]
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes:   Full and empty follow the stored word count exactly.
`timescale 1ns/1ps
module sppi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
  } sppi_fifo_st_t;
  sppi_fifo_st_t st;
  sppi_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic pushNow;
  logic popNow;

  // Handshake terms.
  assign inReady  = (st.count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign outValid = (st.count != '0);
  assign pushNow  = inValid && inReady;
  assign popNow   = outValid && outReady;
  assign outData  = mem[st.rdPtr];
  assign level    = st.count;

  // Pointer and count update.
  always_comb begin
    next_st = st;
    if (pushNow) begin
      next_st.wrPtr = st.wrPtr + AW'(1);
    end
    if (popNow) begin
      next_st.rdPtr = st.rdPtr + AW'(1);
    end
    if (pushNow && !popNow) begin
      next_st.count = st.count + (AW+1)'(1);
    end else if (popNow && !pushNow) begin
      next_st.count = st.count - (AW+1)'(1);
    end
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage array, written without reset.
  always_ff @(posedge clk_sys) begin
    if (pushNow) begin
      mem[st.wrPtr] <= inData;
    end
  end
endmodule

// [hdl/sppi_port.sv]
// Purpose: Three-port programmable parallel interface with handshakes.
// Assumes: Pins are synchronous to clk_sys; AXI4-Lite register access.
// Notes:   Strobed group A input data also flows through an 8-word FIFO.
`timescale 1ns/1ps
module sppi_port
  import sppi_pkg::*;
#(
  parameter int FIFO_DEPTH = SPPI_FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  firstBytePortIn,
  output logic [7:0]       firstBytePortOut,
  output logic [7:0]       firstBytePortOe,
  input  wire logic [7:0]  secondBytePortIn,
  output logic [7:0]       secondBytePortOut,
  output logic [7:0]       secondBytePortOe,
  input  wire logic [7:0]  thirdBytePortIn,
  output logic [7:0]       thirdBytePortOut,
  output logic [7:0]       thirdBytePortOe
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [SPPI_CTL_W-1:0] ctrl;
    logic [7:0]  outA;
    logic [7:0]  outB;
    logic [7:0]  outC;
    logic [7:0]  latA;
    logic [7:0]  latB;
    logic        inputLatchFullA;
    logic        inputLatchFullB;
    logic        outputLatchFullA_n;
    logic        outputLatchFullB_n;
    logic        awHave;
    logic [7:0]  awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } sppi_state_t;
  sppi_state_t st;
  sppi_state_t next_st;

  logic [1:0] modeA;
  logic       modeB;
  logic       hsA;
  logic       biA;
  logic       inStrobeA_n;
  logic       ackA_n;
  logic       inStrobeB_n;
  logic       ackB_n;
  logic       irqA;
  logic       irqB;
  logic       rdStrobe_n;
  logic       wrStrobe_n;
  logic       fifoInReady;
  logic       fifoOutValid;
  logic [7:0] fifoOutData;
  logic       fifoPop;
  logic       fifoPush;
  logic [$clog2(FIFO_DEPTH):0] fifoLevel;

  assign modeA = st.ctrl[SPPI_CTL_MODE_A +: 2];
  assign modeB = st.ctrl[SPPI_CTL_MODE_B];
  assign hsA   = (modeA != SPPI_MODE_SIMPLE);
  assign biA   = (modeA == SPPI_MODE_BIDIR);

  // Handshake lines borrowed from the third port for each group.
  assign inStrobeA_n = thirdBytePortIn[SPPI_PC_STROBE_A];
  assign ackA_n      = thirdBytePortIn[SPPI_PC_ACK_A];
  assign inStrobeB_n = thirdBytePortIn[SPPI_PC_HSK_B];
  assign ackB_n      = thirdBytePortIn[SPPI_PC_HSK_B];

  // Service requests per group, gated by the enable bits.
  assign irqA = st.ctrl[SPPI_CTL_IEN_A] && hsA &&
                (st.inputLatchFullA || (st.outputLatchFullA_n &&
                 (biA || !st.ctrl[SPPI_CTL_DIR_A])));
  assign irqB = st.ctrl[SPPI_CTL_IEN_B] && modeB &&
                (st.ctrl[SPPI_CTL_DIR_B] ? st.inputLatchFullB
                                         : st.outputLatchFullB_n);

  // Internal active-low strobes derived from completed bus phases.
  assign rdStrobe_n = !(s_axi_arvalid && !st.rValid);
  assign wrStrobe_n = !(st.awHave && st.wHave && !st.bValid);

  // ****************************************************************
  // Input FIFO for group A strobed input
  // ****************************************************************
  assign fifoPush = hsA && (biA || st.ctrl[SPPI_CTL_DIR_A]) &&
                    !inStrobeA_n && !st.inputLatchFullA;
  assign fifoPop  = !rdStrobe_n && s_axi_araddr == SPPI_OFF_FIFO;

  sppi_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   (firstBytePortIn),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .level    (fifoLevel)
  );

  // ****************************************************************
  // Bus handshakes and pin drive
  // ****************************************************************
  assign s_axi_awready = !st.awHave;
  assign s_axi_wready  = !st.wHave;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = !st.rValid;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;

  // Port A drives in output modes; in bidirectional only while ack low.
  always_comb begin
    firstBytePortOut  = st.outA;
    firstBytePortOe   = {8{biA ? !ackA_n
                          : !st.ctrl[SPPI_CTL_DIR_A]}};
    secondBytePortOut = st.outB;
    secondBytePortOe  = {8{!st.ctrl[SPPI_CTL_DIR_B]}};
    thirdBytePortOut  = st.outC;
    thirdBytePortOe   = {{4{!st.ctrl[SPPI_CTL_DIR_CH]}},
                         {4{!st.ctrl[SPPI_CTL_DIR_CL]}}};
    if (hsA) begin
      // Group A status lines take over part of the third port.
      thirdBytePortOut[SPPI_PC_SRQ_A]    = irqA;
      thirdBytePortOe[SPPI_PC_SRQ_A]     = 1'b1;
      thirdBytePortOe[SPPI_PC_STROBE_A]  = 1'b0;
      thirdBytePortOe[SPPI_PC_ACK_A]     = 1'b0;
      thirdBytePortOut[SPPI_PC_INFULL_A] = st.inputLatchFullA;
      thirdBytePortOe[SPPI_PC_INFULL_A]  = biA || st.ctrl[SPPI_CTL_DIR_A];
      thirdBytePortOut[SPPI_PC_OUTFULL_A] = st.outputLatchFullA_n;
      thirdBytePortOe[SPPI_PC_OUTFULL_A]  = biA || !st.ctrl[SPPI_CTL_DIR_A];
    end
    if (modeB) begin
      thirdBytePortOut[SPPI_PC_SRQ_B]  = irqB;
      thirdBytePortOe[SPPI_PC_SRQ_B]   = 1'b1;
      thirdBytePortOut[SPPI_PC_FULL_B] = st.ctrl[SPPI_CTL_DIR_B]
                                         ? st.inputLatchFullB
                                         : st.outputLatchFullB_n;
      thirdBytePortOe[SPPI_PC_FULL_B]  = 1'b1;
      thirdBytePortOe[SPPI_PC_HSK_B]   = 1'b0;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    // Strobe low loads the latches; latch full flags rise.
    if (hsA && (biA || st.ctrl[SPPI_CTL_DIR_A]) && !inStrobeA_n) begin
      next_st.latA = firstBytePortIn;
      next_st.inputLatchFullA = 1'b1;
    end
    if (modeB && st.ctrl[SPPI_CTL_DIR_B] && !inStrobeB_n) begin
      next_st.latB = secondBytePortIn;
      next_st.inputLatchFullB = 1'b1;
    end
    // Acknowledge low releases output latch full.
    if (hsA && !ackA_n) begin
      next_st.outputLatchFullA_n = 1'b1;
    end
    if (modeB && !st.ctrl[SPPI_CTL_DIR_B] && !ackB_n) begin
      next_st.outputLatchFullB_n = 1'b1;
    end
    // Write channel capture.
    if (s_axi_awvalid && !st.awHave) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wHave) begin
      next_st.wHave = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    if (!wrStrobe_n) begin
      next_st.awHave = 1'b0;
      next_st.wHave  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = SPPI_RESP_OKAY;
      case (st.awAddr)
        SPPI_OFF_DATA_A: begin
          if (st.wStrb[0]) begin
            next_st.outA = st.wData[7:0];
            if (hsA) begin
              next_st.outputLatchFullA_n = 1'b0;
            end
          end
        end
        SPPI_OFF_DATA_B: begin
          if (st.wStrb[0]) begin
            next_st.outB = st.wData[7:0];
            if (modeB && !st.ctrl[SPPI_CTL_DIR_B]) begin
              next_st.outputLatchFullB_n = 1'b0;
            end
          end
        end
        SPPI_OFF_DATA_C: begin
          if (st.wStrb[0]) begin
            next_st.outC = st.wData[7:0];
          end
        end
        SPPI_OFF_CTRL: begin
          if (st.wStrb[0]) begin
            next_st.ctrl[7:0] = st.wData[7:0];
          end
          if (st.wStrb[1]) begin
            next_st.ctrl[SPPI_CTL_IEN_B] = st.wData[SPPI_CTL_IEN_B];
          end
        end
        default: begin
          next_st.bResp = SPPI_RESP_SLVERR;
        end
      endcase
    end
    // Read channel.
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
    if (!rdStrobe_n) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = SPPI_RESP_OKAY;
      next_st.rData  = '0;
      case (s_axi_araddr)
        SPPI_OFF_DATA_A: begin
          next_st.rData[7:0] = hsA ? st.latA : firstBytePortIn;
          if (hsA && inStrobeA_n) begin
            next_st.inputLatchFullA = 1'b0;
          end
        end
        SPPI_OFF_DATA_B: begin
          next_st.rData[7:0] = modeB ? st.latB : secondBytePortIn;
          if (modeB && inStrobeB_n) begin
            next_st.inputLatchFullB = 1'b0;
          end
        end
        SPPI_OFF_DATA_C: next_st.rData[7:0] = thirdBytePortIn;
        SPPI_OFF_CTRL:   next_st.rData[SPPI_CTL_W-1:0] = st.ctrl;
        SPPI_OFF_STATUS: begin
          next_st.rData[7:0] = {fifoInReady, fifoOutValid, irqB, irqA,
                                !st.outputLatchFullB_n,
                                !st.outputLatchFullA_n,
                                st.inputLatchFullB, st.inputLatchFullA};
          next_st.rData[SPPI_STAT_LEVEL +: 4] = 4'(fifoLevel);
        end
        SPPI_OFF_FIFO: next_st.rData[7:0] = fifoOutData;
        default: next_st.rResp = SPPI_RESP_SLVERR;
      endcase
    end
  end

  // Reset: all inputs, simple mode, handshakes idle, enables clear.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st                    <= '0;
      st.ctrl               <= SPPI_CTL_RESET;
      st.outputLatchFullA_n <= 1'b1;
      st.outputLatchFullB_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// [verification/sppi_periph.sv]
// Purpose: Peripheral model on the group A handshake lines.
// Assumes: Undriven lines sit at the pull-up level.
// Notes:   The bench sets the acknowledge delay.
`timescale 1ns/1ps
module sppi_periph (
  input  wire logic       clk_sys,
  input  wire logic       sendReq,
  input  wire logic [7:0] sendData,
  input  wire logic [3:0] ackWait,
  input  wire logic       outFullN,
  input  wire logic [7:0] portIn,
  output logic [7:0]      dataOut,
  output logic            strobeN,
  output logic            ackN,
  output logic [7:0]      rxByte
);
  logic [3:0] waitCnt = 4'h0;
  initial begin
    dataOut = 8'hFF;
    strobeN = 1'b1;
    ackN = 1'b1;
    rxByte = 8'h00;
  end
  // Data and strobe go out together, then both return to pull-up.
  always @(posedge clk_sys) begin
    dataOut <= sendReq ? sendData : 8'hFF;
    strobeN <= !sendReq;
  end
  // A full output latch is acknowledged after the set delay.
  always @(posedge clk_sys) begin
    ackN <= 1'b1;
    if (!ackN) begin
      rxByte <= portIn;
      waitCnt <= 4'h0;
    end else if (outFullN) begin
      waitCnt <= 4'h0;
    end else if (waitCnt == ackWait) begin
      ackN <= 1'b0;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// [verification/sppi_port_chk.sv]
// Purpose: Assertions on the port block's pins and bus.
// Assumes: One clock and an active-high asynchronous reset.
// Notes:   Handshake lines are recognised by their enables.
`timescale 1ns/1ps
module sppi_port_chk
  import sppi_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [7:0] firstBytePortOe,
  input wire logic [7:0] secondBytePortOe,
  input wire logic [7:0] thirdBytePortIn,
  input wire logic [7:0] thirdBytePortOut,
  input wire logic [7:0] thirdBytePortOe
);
  logic awA;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Notes whether the last accepted write address was port A data.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awA <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awA <= (s_axi_awaddr == SPPI_OFF_DATA_A);
    end
  end
  reset_oe_a: assert property (
    disable iff (1'b0) rst |-> {firstBytePortOe, secondBytePortOe,
    thirdBytePortOe} == 24'h0) else $error("Pin driven in reset.");
  latch_full_a: assert property (
    thirdBytePortOe[5] && !thirdBytePortOe[4] && !thirdBytePortIn[4]
    |=> thirdBytePortOut[5]) else $error("Latch full missing.");
  out_full_a: assert property (
    $rose(s_axi_bvalid) && awA && thirdBytePortOe[7] && !thirdBytePortOe[6]
    && thirdBytePortIn[6] |-> ##[0:1] !thirdBytePortOut[7])
    else $error("Output full missing.");
  ack_free_a: assert property (
    thirdBytePortOe[7] && !thirdBytePortOe[6] && !thirdBytePortIn[6]
    |-> ##[0:1] thirdBytePortOut[7]) else $error("Output full stuck.");
  srq_cause_a: assert property (
    thirdBytePortOe[3] && thirdBytePortOut[3] && (thirdBytePortOe[5] &&
    !thirdBytePortOe[4] || thirdBytePortOe[7] && !thirdBytePortOe[6])
    |-> thirdBytePortOe[5] && thirdBytePortOut[5] || thirdBytePortOe[7]
    && thirdBytePortOut[7]) else $error("Request without cause.");
  wr_done_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write answer repeated.");
  rd_done_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read answer repeated.");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
endmodule
bind sppi_port sppi_port_chk chk (.*);

// [verification/strobed_parallel_io_port_bench.sv]
// Purpose: Register-level tests of the port block.
// Assumes: Undriven pins sit at the pull-up level.
// Notes:   A model acknowledges group A output data.
`timescale 1ns/1ps
module strobed_parallel_io_port_bench
  import sppi_pkg::*;
;
  logic clk_sys = 1'b0, rst = 1'b0, bStrobe = 1'b1, sendReq = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF, ackWait = 4'h2;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pStrobe, pAck;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] firstBytePortIn, firstBytePortOut, firstBytePortOe;
  logic [7:0] secondBytePortIn, secondBytePortOut, secondBytePortOe;
  logic [7:0] thirdBytePortIn, thirdBytePortOut, thirdBytePortOe;
  logic [7:0] bIn = 8'hFF, sendData = 8'h00, pData, rxByte;
  int failCount = 0, nTests = 0;
  // Each pin reads back its own drive, else the far side or pull-up.
  assign firstBytePortIn = firstBytePortOe & firstBytePortOut
    | ~firstBytePortOe & pData;
  assign secondBytePortIn = secondBytePortOe & secondBytePortOut
    | ~secondBytePortOe & bIn;
  assign thirdBytePortIn = thirdBytePortOe & thirdBytePortOut
    | ~thirdBytePortOe & {1'b1, pAck, 1'b1, pStrobe, 1'b1, bStrobe, 2'b11};
  always #20 clk_sys = ~clk_sys;
  sppi_port #(.FIFO_DEPTH(8)) dut (.*);
  sppi_periph peer (.clk_sys(clk_sys), .sendReq(sendReq),
    .sendData(sendData), .ackWait(ackWait), .outFullN(thirdBytePortIn[7]),
    .portIn(firstBytePortIn), .dataOut(pData), .strobeN(pStrobe),
    .ackN(pAck), .rxByte(rxByte));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(SPPI_RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    check(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic send(input logic [7:0] d);
    @(posedge clk_sys);
    sendReq <= 1'b1;
    sendData <= d;
    @(posedge clk_sys);
    sendReq <= 1'b0;
    tick(3);
  endtask
  task automatic printVerdict;
    $display("Checks %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #200us;
    failCount++;
    printVerdict;
  end
  // Main sequence of register-level tests.
  initial begin
    // Raised at time zero by a nonblocking assignment so that the reset edge is seen by the flops.
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    check({firstBytePortOe, secondBytePortOe, thirdBytePortOe}, 0);
    rd(SPPI_OFF_CTRL, SPPI_RESP_OKAY);
    check(v[8:0], 9'h00F);
    rd(SPPI_OFF_STATUS, SPPI_RESP_OKAY);
    check({v[7:4], v[1:0]}, 6'h20);
    rd(8'h18, SPPI_RESP_SLVERR);
    wr(SPPI_OFF_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) wr(8'(4 * i), 32'hC0 + i);
    check({firstBytePortOut, secondBytePortOut, thirdBytePortOut},
      24'hC0C1C2);
    check({firstBytePortOe, secondBytePortOe, thirdBytePortOe},
      24'hFFFFFF);
    wr(SPPI_OFF_CTRL, 32'h00F);
    bIn <= 8'h3C;
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i), SPPI_RESP_OKAY);
      check(v[7:0], (i == 1) ? 8'h3C : 8'hFF);
    end
    wr(SPPI_OFF_CTRL, 32'h09F);
    send(8'h77);
    check(thirdBytePortOut[5:3], 3'b101);
    rd(SPPI_OFF_DATA_A, SPPI_RESP_OKAY);
    check(v[7:0], 8'h77);
    tick(2);
    check(thirdBytePortOut[5:3], 3'b000);
    for (int i = 1; i < 9; i++) begin
      send(8'h10 + 8'(i));
      rd(SPPI_OFF_DATA_A, SPPI_RESP_OKAY);
      check(v[7:0], 8'h10 + 8'(i));
    end
    rd(SPPI_OFF_STATUS, SPPI_RESP_OKAY);
    check(v[11:6], 6'h21);
    for (int i = 0; i < 8; i++) begin
      rd(SPPI_OFF_FIFO, SPPI_RESP_OKAY);
      check(v[7:0], (i == 0) ? 8'h77 : 8'h10 + 8'(i));
    end
    rd(SPPI_OFF_STATUS, SPPI_RESP_OKAY);
    check(v[11:6], 6'h02);
    wr(SPPI_OFF_CTRL, 32'h01F);
    send(8'h42);
    check(thirdBytePortOut[5:3], 3'b100);
    rd(SPPI_OFF_DATA_A, SPPI_RESP_OKAY);
    wr(SPPI_OFF_CTRL, 32'h09E);
    wr(SPPI_OFF_DATA_A, 32'hC3);
    check(thirdBytePortOut[7], 1'b0);
    check(firstBytePortOut, 8'hC3);
    tick(8);
    check(rxByte, 8'hC3);
    check({thirdBytePortOut[7], thirdBytePortOut[3]}, 2'b11);
    ackWait <= 4'h6;
    wr(SPPI_OFF_CTRL, 32'h0AF);
    wr(SPPI_OFF_DATA_A, 32'h69);
    check(firstBytePortOe, 8'h00);
    tick(12);
    check(rxByte, 8'h69);
    send(8'h12);
    rd(SPPI_OFF_DATA_A, SPPI_RESP_OKAY);
    check(v[7:0], 8'h12);
    wr(SPPI_OFF_CTRL, 32'h14F);
    bIn <= 8'h4B;
    bStrobe <= 1'b0;
    tick(1);
    bStrobe <= 1'b1;
    tick(2);
    check(thirdBytePortOut[1:0], 2'b11);
    rd(SPPI_OFF_DATA_B, SPPI_RESP_OKAY);
    check(v[7:0], 8'h4B);
    tick(2);
    check(thirdBytePortOut[1:0], 2'b00);
    // Group B strobed output, acknowledged on the shared line.
    wr(SPPI_OFF_CTRL, 32'h14D);
    wr(SPPI_OFF_DATA_B, 32'h5A);
    check(secondBytePortOe, 8'hFF);
    check({secondBytePortOut, thirdBytePortOut[1:0]}, 10'h168);
    bStrobe <= 1'b0;
    tick(1);
    bStrobe <= 1'b1;
    tick(2);
    check(thirdBytePortOut[1:0], 2'b11);
    printVerdict;
  end
endmodule
